// file: dv/fourier_prep_model.sv
`timescale 1ns/10ps
module fourier_prep_model
(
  input  wire logic               clk,
  input  wire logic               load,
  input  wire logic [3:0]         lag,
  input  wire logic signed [15:0] set_re [4],
  input  wire logic signed [15:0] set_im [4],
  input  wire logic               set_ub,
  input  wire logic               set_sr,
  output logic signed [15:0]      phase1_re,
  output logic signed [15:0]      phase1_im,
  output logic signed [15:0]      phase2_re,
  output logic signed [15:0]      phase2_im,
  output logic signed [15:0]      phase3_re,
  output logic signed [15:0]      phase3_im,
  output logic signed [15:0]      neutral_re,
  output logic signed [15:0]      neutral_im,
  output logic                    user_block_in,
  output logic                    sens_raise_in
);
  logic [3:0] wait_reg;
  logic       busy_reg;
  ////////////////////////////////////////////////////////////////////
  // Everything starts quiet so the design sees no unknowns
  initial
  begin
    wait_reg = 4'h0;
    busy_reg = 1'b0;
    {phase1_re, phase1_im, phase2_re, phase2_im} = 64'h0;
    {phase3_re, phase3_im, neutral_re, neutral_im} = 64'h0;
    {user_block_in, sens_raise_in} = 2'h0;
  end
  ////////////////////////////////////////////////////////////////////
  // Lag mimics a slow upstream stage; all values change in one cycle
  always @(posedge clk)
  begin
    if (load)
    begin
      wait_reg <= lag;
      busy_reg <= 1'b1;
    end
    else if (busy_reg && wait_reg != 4'h0)
      wait_reg <= wait_reg - 4'h1;
    else if (busy_reg)
    begin
      busy_reg <= 1'b0;
      {phase1_re, phase2_re} <= {set_re[0], set_re[1]};
      {phase3_re, neutral_re} <= {set_re[2], set_re[3]};
      {phase1_im, phase2_im} <= {set_im[0], set_im[1]};
      {phase3_im, neutral_im} <= {set_im[2], set_im[3]};
      user_block_in <= set_ub;
      sens_raise_in <= set_sr;
    end
  end
endmodule : fourier_prep_model

// file: dv/test_zero_seq_diff_function.sv
`timescale 1ns/10ps
module test_zero_seq_diff_function;
  logic               clk, rst, wr, rd, load, ub, sr;
  logic [7:0]         addr;
  logic [31:0]        wdata, rdata, rv;
  logic [3:0]         lag;
  logic signed [15:0] sre [4];
  logic signed [15:0] sim [4];
  logic signed [15:0] phase1_re, phase1_im, phase2_re, phase2_im;
  logic signed [15:0] phase3_re, phase3_im, neutral_re, neutral_im;
  logic               user_block_in, sens_raise_in, irq;
  logic               general_trip_out, dir_block_flag, char_trip_internal;
  logic [23:0]        diff_current_value, restraint_current_value;
  int                 bad_count, n_checks, op, dck, base, slope, brk;
  int                 phf, ncf;
  logic [7:0]         ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
                                  8'h14, 8'h20, 8'h24, 8'h28, 8'h30};
  logic [31:0]        va [10] = '{32'h3, 32'h1E, 32'h46, 32'h7D, 32'h64,
                                  32'h1F4, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [7:0]         ca [8] = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h0C,
                                 8'h0C, 8'h10, 8'h14};
  logic [31:0]        cw [8] = '{32'h0, 32'h3FF, 32'h0, 32'h3FF, 32'h0,
                                 32'h3FF, 32'h0, 32'h3FF};
  logic [31:0]        cv [8] = '{32'h0A, 32'h32, 32'h32, 32'h64, 32'h64,
                                 32'hC8, 32'h14, 32'h3E8};
  ////////////////////////////////////////////////////////////////////
  fourier_prep_model fourier_prep_model_inst
  (
    .clk, .load, .lag, .set_re(sre), .set_im(sim), .set_ub(ub),
    .set_sr(sr), .phase1_re, .phase1_im, .phase2_re, .phase2_im,
    .phase3_re, .phase3_im, .neutral_re, .neutral_im,
    .user_block_in, .sens_raise_in
  );
  zero_seq_diff_function zero_seq_diff_function_inst
  (
    .clk, .rst, .phase1_re, .phase1_im, .phase2_re, .phase2_im,
    .phase3_re, .phase3_im, .neutral_re, .neutral_im, .user_block_in,
    .sens_raise_in, .addr, .wdata, .wr, .rd, .rdata, .general_trip_out,
    .dir_block_flag, .char_trip_internal, .diff_current_value,
    .restraint_current_value, .irq
  );
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Whole run is a few hundred cycles
  initial
  begin
    #50000;
    bad_count++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Settling delay keeps an irq check off the launching edge
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wreg

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, e);
  endtask : rchk

  function automatic int cmp(input int v, input int f);
    return v * 100 / f;
  endfunction : cmp

  function automatic int mg(input int a, input int b);
    int x;
    int y;
    int t;
    x = a < 0 ? -a : a;
    y = b < 0 ? -b : b;
    if (y > x)
    begin
      t = x;
      x = y;
      y = t;
    end
    return x + y / 4 + y / 8;
  endfunction : mg

  // Phase phasors stay real; neutral may carry an imaginary part
  task automatic apply(input int a, b, c, n, ni, input logic u, s,
                       input int l);
    int         zr;
    int         nc;
    int         nci;
    int         d;
    int         bi;
    int         thr;
    int         pc [3];
    logic       dr;
    logic       ch;
    @(posedge clk);
    sre[0] <= 16'(a);
    sre[1] <= 16'(b);
    sre[2] <= 16'(c);
    sre[3] <= 16'(n);
    sim[3] <= 16'(ni);
    {ub, sr, lag, load} <= {u, s, 4'(l), 1'b1};
    @(posedge clk);
    load <= 1'b0;
    repeat (l + 6) @(posedge clk);
    #1;
    pc = '{cmp(a, phf), cmp(b, phf), cmp(c, phf)};
    zr = pc[0] + pc[1] + pc[2];
    nc = cmp(n, ncf);
    nci = cmp(ni, ncf);
    d = mg(nc - zr, nci);
    bi = mg(nc, nci);
    foreach (pc[i])
      if (mg(pc[i], 0) > bi)
        bi = mg(pc[i], 0);
    dr = zr * nc < 0;
    thr = s ? base * 250 : base * 1000;
    if (bi > brk * 10)
      thr = thr + slope * (bi - brk * 10);
    ch = d * 100 > thr;
    check(32'(diff_current_value), 32'(d));
    check(32'(restraint_current_value), 32'(bi));
    check(32'(dir_block_flag), 32'(dr));
    check(32'(char_trip_internal), 32'(ch));
    check(32'(general_trip_out),
          32'(ch && op && !(dr && dck) && !u));
  endtask : apply
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst, wr, rd, load, ub, sr} = 6'h20;
    {addr, wdata, lag} = 44'h0;
    sre = '{default: 16'h0};
    sim = '{default: 16'h0};
    {bad_count, n_checks, op, dck} = {32'd0, 32'd0, 32'd1, 32'd1};
    {base, slope, brk} = {32'd30, 32'd70, 32'd125};
    {phf, ncf} = {32'd100, 32'd500};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i])
      rchk(ra[i], va[i]);
    wreg(8'h24, 32'h1);
    apply(100, 60, 40, 3000, 0, 0, 0, 0);
    check(32'(irq), 32'h1);
    rchk(8'h20, 32'h5);
    rchk(8'h28, 32'h5);
    wreg(8'h20, 32'h5);
    rchk(8'h20, 32'h0);
    check(32'(irq), 32'h0);
    // Read-only value must ignore the write
    wreg(8'h18, 32'h0);
    rchk(8'h18, 32'd400);
    rchk(8'h1C, 32'h258);
    apply(200, 0, 0, -3000, 0, 0, 0, 5);
    rchk(8'h20, 32'h2);
    wreg(8'h00, 32'h1);
    dck = 0;
    apply(200, 0, 0, -3000, 0, 0, 0, 0);
    wreg(8'h00, 32'h0);
    op = 0;
    apply(100, 60, 40, 3000, 0, 0, 0, 0);
    wreg(8'h00, 32'h3);
    {op, dck} = {32'd1, 32'd1};
    apply(100, 60, 40, 3000, 0, 1, 0, 3);
    apply(200, 0, 0, 2500, 0, 0, 0, 0);
    apply(200, 0, 0, 2500, 0, 0, 1, 0);
    apply(2000, 0, 0, 12000, 0, 0, 0, 0);
    apply(200, 0, 0, 0, 3000, 0, 0, 0);
    wreg(8'h10, 32'd200);
    phf = 200;
    apply(400, 0, 0, 3000, 0, 0, 0, 2);
    wreg(8'h24, 32'h0);
    check(32'(irq), 32'h0);
    wreg(8'h24, 32'h7);
    check(32'(irq), 32'h1);
    // Out-of-range settings clamp instead of being dropped
    foreach (ca[i])
    begin
      wreg(ca[i], cw[i]);
      rchk(ca[i], cv[i]);
    end
    summarize();
  end
endmodule : test_zero_seq_diff_function

// file: include/zsd_pkg.sv
// Behaviour
// - Sum the three compensated phase phasors into zero sequence.
// - Direction flag when zero sequence to neutral angle exceeds 90 deg.
// - Restraint current is the largest phase or neutral magnitude.
// - Characteristic trip when differential exceeds curve at restraint.
// - Base sensitivity 10 to 50 percent, unit step, default 30.
// - Slope 50 to 100 percent of bias, unit step, default 70.
// - Breakpoint 100 to 200 percent, unit step, default 125.
// - Raise input divides base threshold by four, driven from outside.
// - Differential and restraint currents readable, scaled at 0.1 percent per LSB.
// - Directional flag blocks only when the directional check is enabled.
// - Operation Off or On, default On; Off never trips.
// - Trip needs characteristic flag, no blocking and operation On.
// - Blocking is enabled directional flag or user blocking input.
// - Directional flag is exported beside the general trip.
// - Phase comp 20 to 500 default 100; neutral 100 to 1000 default 500.
package zsd_pkg;
  localparam int IW = 16;
  localparam int CW = 20;
  localparam int MW = 24;
  localparam int SW = 10;
  localparam int AW = 8;
  ////////////////////////////////////////////////////////////////////
  localparam logic [AW-1:0] CTRL_OFS   = 8'h00;
  localparam logic [AW-1:0] BASE_OFS   = 8'h04;
  localparam logic [AW-1:0] SLOPE_OFS  = 8'h08;
  localparam logic [AW-1:0] BRK_OFS    = 8'h0C;
  localparam logic [AW-1:0] PHCMP_OFS  = 8'h10;
  localparam logic [AW-1:0] NCMP_OFS   = 8'h14;
  localparam logic [AW-1:0] DIFF_OFS   = 8'h18;
  localparam logic [AW-1:0] BIAS_OFS   = 8'h1C;
  localparam logic [AW-1:0] STAT_OFS   = 8'h20;
  localparam logic [AW-1:0] MASK_OFS   = 8'h24;
  localparam logic [AW-1:0] FLAGS_OFS  = 8'h28;
  ////////////////////////////////////////////////////////////////////
  localparam int CTRL_OP_BIT  = 0;
  localparam int CTRL_DIR_BIT = 1;
  localparam int EV_TRIP_BIT  = 0;
  localparam int EV_DIR_BIT   = 1;
  localparam int EV_CHAR_BIT  = 2;
  localparam int EVW          = 3;
  ////////////////////////////////////////////////////////////////////
  localparam logic [1:0]    CTRL_RST  = 2'h3;
  localparam logic [SW-1:0] BASE_RST  = 10'h01E;
  localparam logic [SW-1:0] BASE_MIN  = 10'h00A;
  localparam logic [SW-1:0] BASE_MAX  = 10'h032;
  localparam logic [SW-1:0] SLOPE_RST = 10'h046;
  localparam logic [SW-1:0] SLOPE_MIN = 10'h032;
  localparam logic [SW-1:0] SLOPE_MAX = 10'h064;
  localparam logic [SW-1:0] BRK_RST   = 10'h07D;
  localparam logic [SW-1:0] BRK_MIN   = 10'h064;
  localparam logic [SW-1:0] BRK_MAX   = 10'h0C8;
  localparam logic [SW-1:0] PHC_RST   = 10'h064;
  localparam logic [SW-1:0] PHC_MIN   = 10'h014;
  localparam logic [SW-1:0] PHC_MAX   = 10'h1F4;
  localparam logic [SW-1:0] NC_RST    = 10'h1F4;
  localparam logic [SW-1:0] NC_MIN    = 10'h064;
  localparam logic [SW-1:0] NC_MAX    = 10'h3E8;
  localparam logic [EVW-1:0] MASK_RST = 3'h0;
  ////////////////////////////////////////////////////////////////////
  // Currents carry 0.1 percent per LSB
  localparam int PCT_SCALE  = 10;
  localparam int PCT_FULL   = 100;
  localparam int SENS_RAISE = 4;
  localparam int LATENCY    = 3;
endpackage : zsd_pkg

// file: verilog/zero_seq_diff_function.sv
`timescale 1ns/10ps
module zero_seq_diff_function
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic signed [15:0]        phase1_re,
  input  wire logic signed [15:0]        phase1_im,
  input  wire logic signed [15:0]        phase2_re,
  input  wire logic signed [15:0]        phase2_im,
  input  wire logic signed [15:0]        phase3_re,
  input  wire logic signed [15:0]        phase3_im,
  input  wire logic signed [15:0]        neutral_re,
  input  wire logic signed [15:0]        neutral_im,
  input  wire logic                      user_block_in,
  input  wire logic                      sens_raise_in,
  input  wire logic [7:0]                addr,
  input  wire logic [31:0]               wdata,
  input  wire logic                      wr,
  input  wire logic                      rd,
  output logic      [31:0]               rdata,
  output logic                           general_trip_out,
  output logic                           dir_block_flag,
  output logic                           char_trip_internal,
  output logic      [23:0]               diff_current_value,
  output logic      [23:0]               restraint_current_value,
  output logic                           irq
);
  localparam int CW = zsd_pkg::CW;
  localparam int MW = zsd_pkg::MW;
  localparam int SW = zsd_pkg::SW;

  function automatic logic signed [CW-1:0] comp
  (
    input logic signed [15:0] v,
    input logic [SW-1:0]      f
  );
    logic signed [31:0] n;
    logic signed [31:0] q;
    n = 32'(v) * 32'(zsd_pkg::PCT_FULL);
    q = n / $signed({22'h000000, f});
    return q[CW-1:0];
  endfunction : comp

  // Max plus 3/8 min keeps error near 7 percent without a root
  function automatic logic [MW-1:0] mag
  (
    input logic signed [MW-1:0] re,
    input logic signed [MW-1:0] im
  );
    logic [MW-1:0] a;
    logic [MW-1:0] b;
    logic [MW-1:0] mx;
    logic [MW-1:0] mn;
    a  = re[MW-1] ? MW'(-re) : MW'(re);
    b  = im[MW-1] ? MW'(-im) : MW'(im);
    mx = (a > b) ? a : b;
    mn = (a > b) ? b : a;
    return mx + (mn >> 2) + (mn >> 3);
  endfunction : mag

  function automatic logic [SW-1:0] clamp
  (
    input logic [31:0]   v,
    input logic [SW-1:0] lo,
    input logic [SW-1:0] hi
  );
    logic [SW-1:0] r;
    r = (v < 32'(lo)) ? lo : ((v > 32'(hi)) ? hi : v[SW-1:0]);
    return r;
  endfunction : clamp

  ////////////////////////////////////////////////////////////////////
  // Settings and interrupt registers
  logic [1:0]    ctrl_reg,  ctrl_next;
  logic [SW-1:0] base_reg,  base_next;
  logic [SW-1:0] slope_reg, slope_next;
  logic [SW-1:0] brk_reg,   brk_next;
  logic [SW-1:0] phc_reg,   phc_next;
  logic [SW-1:0] nc_reg,    nc_next;
  logic [2:0]    stat_reg,  stat_next;
  logic [2:0]    mask_reg,  mask_next;
  logic [31:0]   rdata_reg, rdata_next;
  logic [2:0]    ev;
  logic          op_on;
  logic          dir_en;

  assign op_on  = ctrl_reg[zsd_pkg::CTRL_OP_BIT];
  assign dir_en = ctrl_reg[zsd_pkg::CTRL_DIR_BIT];

  always_comb
  begin
    ctrl_next  = ctrl_reg;
    base_next  = base_reg;
    slope_next = slope_reg;
    brk_next   = brk_reg;
    phc_next   = phc_reg;
    nc_next    = nc_reg;
    mask_next  = mask_reg;
    stat_next  = stat_reg;
    rdata_next = 32'h00000000;
    if (wr)
    begin
      if (addr == zsd_pkg::CTRL_OFS)
        ctrl_next = wdata[1:0];
      else if (addr == zsd_pkg::BASE_OFS)
        base_next = clamp(wdata, zsd_pkg::BASE_MIN, zsd_pkg::BASE_MAX);
      else if (addr == zsd_pkg::SLOPE_OFS)
        slope_next = clamp(wdata, zsd_pkg::SLOPE_MIN, zsd_pkg::SLOPE_MAX);
      else if (addr == zsd_pkg::BRK_OFS)
        brk_next = clamp(wdata, zsd_pkg::BRK_MIN, zsd_pkg::BRK_MAX);
      else if (addr == zsd_pkg::PHCMP_OFS)
        phc_next = clamp(wdata, zsd_pkg::PHC_MIN, zsd_pkg::PHC_MAX);
      else if (addr == zsd_pkg::NCMP_OFS)
        nc_next = clamp(wdata, zsd_pkg::NC_MIN, zsd_pkg::NC_MAX);
      else if (addr == zsd_pkg::STAT_OFS)
        stat_next = stat_reg & ~wdata[2:0];
      else if (addr == zsd_pkg::MASK_OFS)
        mask_next = wdata[2:0];
    end
    // Set beats a clear in the same cycle
    stat_next = stat_next | ev;
    if (rd)
    begin
      if (addr == zsd_pkg::CTRL_OFS)
        rdata_next = {30'h00000000, ctrl_reg};
      else if (addr == zsd_pkg::BASE_OFS)
        rdata_next = {22'h000000, base_reg};
      else if (addr == zsd_pkg::SLOPE_OFS)
        rdata_next = {22'h000000, slope_reg};
      else if (addr == zsd_pkg::BRK_OFS)
        rdata_next = {22'h000000, brk_reg};
      else if (addr == zsd_pkg::PHCMP_OFS)
        rdata_next = {22'h000000, phc_reg};
      else if (addr == zsd_pkg::NCMP_OFS)
        rdata_next = {22'h000000, nc_reg};
      else if (addr == zsd_pkg::DIFF_OFS)
        rdata_next = {8'h00, diff_current_value};
      else if (addr == zsd_pkg::BIAS_OFS)
        rdata_next = {8'h00, restraint_current_value};
      else if (addr == zsd_pkg::STAT_OFS)
        rdata_next = {29'h00000000, stat_reg};
      else if (addr == zsd_pkg::MASK_OFS)
        rdata_next = {29'h00000000, mask_reg};
      else if (addr == zsd_pkg::FLAGS_OFS)
        rdata_next = {29'h00000000, char_trip_internal,
                      dir_block_flag, general_trip_out};
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_reg  <= zsd_pkg::CTRL_RST;
      base_reg  <= zsd_pkg::BASE_RST;
      slope_reg <= zsd_pkg::SLOPE_RST;
      brk_reg   <= zsd_pkg::BRK_RST;
      phc_reg   <= zsd_pkg::PHC_RST;
      nc_reg    <= zsd_pkg::NC_RST;
      stat_reg  <= 3'h0;
      mask_reg  <= zsd_pkg::MASK_RST;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      ctrl_reg  <= ctrl_next;
      base_reg  <= base_next;
      slope_reg <= slope_next;
      brk_reg   <= brk_next;
      phc_reg   <= phc_next;
      nc_reg    <= nc_next;
      stat_reg  <= stat_next;
      mask_reg  <= mask_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;
  assign irq   = |(stat_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////
  // Stage 1: magnitude compensation
  logic signed [CW-1:0] c_reg [8];
  logic signed [CW-1:0] c_next [8];

  always_comb
  begin
    c_next[0] = comp(phase1_re, phc_reg);
    c_next[1] = comp(phase1_im, phc_reg);
    c_next[2] = comp(phase2_re, phc_reg);
    c_next[3] = comp(phase2_im, phc_reg);
    c_next[4] = comp(phase3_re, phc_reg);
    c_next[5] = comp(phase3_im, phc_reg);
    c_next[6] = comp(neutral_re, nc_reg);
    c_next[7] = comp(neutral_im, nc_reg);
  end

  always_ff @(posedge clk)
  begin
    for (int k = 0; k < 8; k++)
      c_reg[k] <= rst ? '0 : c_next[k];
  end

  ////////////////////////////////////////////////////////////////////
  // Stage 2: zero sequence, direction, differential, bias
  logic signed [MW-1:0] z_re, z_im, n_re, n_im;
  logic signed [2*MW-1:0] dot;
  logic          dot_neg;
  logic [MW-1:0] m1, m2, m3, mn, mb01, mb23;
  logic [MW-1:0] diff_reg, diff_next, bias_reg, bias_next;
  logic          dir_reg, dir_next;

  always_comb
  begin
    n_re = MW'(c_reg[6]);
    n_im = MW'(c_reg[7]);
    z_re = MW'(c_reg[0]) + MW'(c_reg[2]) + MW'(c_reg[4]);
    z_im = MW'(c_reg[1]) + MW'(c_reg[3]) + MW'(c_reg[5]);
    // Negative dot product means more than 90 degrees apart
    dot = (2*MW)'(z_re) * (2*MW)'(n_re) + (2*MW)'(z_im) * (2*MW)'(n_im);
    dot_neg   = dot[2*MW-1];
    dir_next  = dot_neg;
    diff_next = mag(n_re - z_re, n_im - z_im);
    m1 = mag(MW'(c_reg[0]), MW'(c_reg[1]));
    m2 = mag(MW'(c_reg[2]), MW'(c_reg[3]));
    m3 = mag(MW'(c_reg[4]), MW'(c_reg[5]));
    mn = mag(n_re, n_im);
    mb01 = (m1 > m2) ? m1 : m2;
    mb23 = (m3 > mn) ? m3 : mn;
    bias_next = (mb01 > mb23) ? mb01 : mb23;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dir_reg  <= 1'b0;
      diff_reg <= '0;
      bias_reg <= '0;
    end
    else
    begin
      dir_reg  <= dir_next;
      diff_reg <= diff_next;
      bias_reg <= bias_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Stage 3: characteristic and decision
  logic [47:0] lhs, rhs, base_term, slope_term, brk_pt;
  logic        char_next, trip_next, block;
  logic        char_reg, trip_reg;

  always_comb
  begin
    // Raised sensitivity lowers the base threshold fourfold; the slope term is unchanged
    base_term = 48'(base_reg) * 48'(zsd_pkg::PCT_SCALE * zsd_pkg::PCT_FULL);
    if (sens_raise_in)
      base_term = base_term / 48'(zsd_pkg::SENS_RAISE);
    brk_pt = 48'(brk_reg) * 48'(zsd_pkg::PCT_SCALE);
    slope_term = 48'h0;
    if (48'(bias_reg) > brk_pt)
      slope_term = 48'(slope_reg) * (48'(bias_reg) - brk_pt);
    lhs = 48'(diff_reg) * 48'(zsd_pkg::PCT_FULL);
    rhs = base_term + slope_term;
    char_next = lhs > rhs;
    block = (dir_en && dir_reg) || user_block_in;
    trip_next = char_next && !block && op_on;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      char_reg <= 1'b0;
      trip_reg <= 1'b0;
    end
    else
    begin
      char_reg <= char_next;
      trip_reg <= trip_next;
    end
  end

  assign char_trip_internal      = char_reg;
  assign general_trip_out        = trip_reg;
  assign dir_block_flag          = dir_reg;
  assign diff_current_value      = diff_reg;
  assign restraint_current_value = bias_reg;
  assign ev = {char_next & ~char_reg, dir_next & ~dir_reg,
               trip_next & ~trip_reg};

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_dir_sign: assert property (##1 dir_block_flag == $past(dot_neg))
    else $error("direction flag does not follow phasor angle");
  a_bias_max: assert property (##1 bias_reg >= $past(mn))
    else $error("restraint below neutral magnitude");
  a_char_zero: assert property ($past(diff_reg) == '0 |-> !char_reg)
    else $error("characteristic trip with zero differential");
  a_base_range: assert property (base_reg >= zsd_pkg::BASE_MIN &&
      base_reg <= zsd_pkg::BASE_MAX)
    else $error("base sensitivity out of range");
  a_slope_range: assert property (slope_reg >= zsd_pkg::SLOPE_MIN &&
      slope_reg <= zsd_pkg::SLOPE_MAX)
    else $error("slope out of range");
  a_brk_range: assert property (brk_reg >= zsd_pkg::BRK_MIN &&
      brk_reg <= zsd_pkg::BRK_MAX)
    else $error("breakpoint out of range");
  a_comp_range: assert property (phc_reg >= zsd_pkg::PHC_MIN &&
      phc_reg <= zsd_pkg::PHC_MAX && nc_reg >= zsd_pkg::NC_MIN &&
      nc_reg <= zsd_pkg::NC_MAX)
    else $error("compensation out of range");
  a_dir_blocks: assert property (dir_en && dir_reg |=> !general_trip_out)
    else $error("trip despite enabled directional block");
  a_user_blocks: assert property (user_block_in |=> !general_trip_out)
    else $error("trip despite user blocking");
  a_off_quiet: assert property (!op_on |=> !general_trip_out)
    else $error("trip while operation off");
  a_trip_cause: assert property (general_trip_out |-> $past(char_next))
    else $error("trip without characteristic flag");
  a_stat_sticky: assert property ($rose(general_trip_out) |-> stat_reg[0])
    else $error("trip event not latched");

  c_trip: cover property ($rose(general_trip_out));
  c_dir_block: cover property (char_reg && dir_reg && !general_trip_out);
  c_raise_trip: cover property (sens_raise_in ##1 char_reg);
  c_irq: cover property ($rose(irq));
endmodule : zero_seq_diff_function
